//--- tb/core_model.sv
// Core stand-in: a program counter that follows vector and restore loads.
// Assumes the controller's pulses are registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module core_model
#(
	parameter logic [irq_ctrl_pkg::PC_W-1:0] START_PC = 13'h0000 // Address held after reset
)
(
	input  wire logic                          clk_in,     // Core clock
	input  wire logic                          rst_n_in,   // Reset, active low
	input  wire logic                          vector_in,  // Load the vector
	input  wire logic                          restore_in, // Load the popped address
	input  wire logic [irq_ctrl_pkg::PC_W-1:0] load_in,    // Value to load
	input  wire logic                          ret_req_in, // Bench asks for a return
	output logic                               ret_out,    // Return instruction pulse
	output logic [irq_ctrl_pkg::PC_W-1:0]      pc_out      // Address offered for push
);
	import irq_ctrl_pkg::*;
	// Only the address changes hands; other context stays with software
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			pc_out <= START_PC;
			ret_out <= 1'h0;
		end
		else
		begin
			ret_out <= ret_req_in;
			if (vector_in || restore_in)
				pc_out <= load_in;
		end
endmodule
`default_nettype wire

//--- tb/mcu_interrupt_controller_tb.sv
// Bench for the interrupt controller: bus master, pin and event drivers, core stand-in.
// Assumes the package and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module mcu_interrupt_controller_tb;
	import irq_ctrl_pkg::*;
	localparam logic [PC_W-1:0] START = 13'h0123;
	logic clk = '0, rst_n = '0, awv = '0, wv = '0, bready = '0, arv = '0, rready = '0;
	logic pin = '0, sleep = '0, ret_req = '0, awr, wr_rdy, bv, arr, rv, vec, rest, wake, irq, ret;
	logic [7:0] awaddr = '0, araddr = '0, tcnt = '0;
	logic [31:0] wdata = '0, rdata, rdv;
	logic [7:4] port = '0;
	logic [PA_W-1:0] ev_a = '0;
	logic [PB_W-1:0] ev_b = '0;
	logic [PC_W-1:0] pc, pc_load;
	logic [1:0] bresp, rresp, resp, qph;
	int mismatches = 0, checks_done = 0, vec_cnt = 0, lat;
	mcu_irq_ctrl u_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .ext_irq_pin_in(pin),
		.upper_port_pins_in(port), .timer_count_in(tcnt), .periph_event_a_in(ev_a), .periph_event_b_in(ev_b),
		.sleep_in(sleep), .return_from_irq_in(ret), .return_pc_in(pc), .vector_out(vec), .pc_load_out(pc_load),
		.restore_out(rest), .wake_out(wake), .qphase_out(qph), .irq_out(irq));
	core_model #(.START_PC(START)) u_core (.clk_in(clk), .rst_n_in(rst_n), .vector_in(vec), .restore_in(rest),
		.load_in(pc_load), .ret_req_in(ret_req), .ret_out(ret), .pc_out(pc));
	// Core clock, 8 ns period
	always #4 clk = ~clk;
	// Count vector pulses mid-cycle, clear of the launching edge
	always @(negedge clk) if (vec === 1'h1) vec_cnt++;
	// Watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end
	// One register access, a write when w is set; answer lands in rdv and resp
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		{awv, wv, bready} <= {3{w}};
		{arv, rready} <= {2{!w}};
		// Wait for the answer as long as it takes; only the watchdog ends a hang
		while (bv !== 1'h1 && rv !== 1'h1)
		begin
			@(posedge clk);
			awv <= awv && !awr;
			wv <= wv && !wr_rdy;
			arv <= arv && !arr;
		end
		rdv = rdata;
		resp = w ? bresp : rresp;
		{bready, rready} <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	// Read a register and compare it
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		`CHK(nm, e, rdv)
	endtask
	// Bounded wait for a vector pulse; lat counts the edges
	task automatic wait_vec();
		for (lat = 0; lat == 0 || (lat < 60 && vec !== 1'h1); lat++)
			@(posedge clk);
		`CHK("vector", 1'h1, vec)
	endtask
	// No vector may be taken for 40 cycles
	task automatic quiet(input string nm);
		int c;
		c = vec_cnt;
		repeat (40) @(posedge clk);
		`CHK(nm, c, vec_cnt)
	endtask
	task automatic t_reset();
		logic [1:0] qp;
		rdc("control", OFF_CONTROL, 32'h0);
		rdc("option", OFF_OPTION, 32'hff);
		rdc("unmapped", 8'h20, 32'h0);
		`CHK("unmapped resp", RESP_SLVERR, resp)
		// Quarter-cycle phase steps by one each clock
		qp = qph + 2'h1;
		@(posedge clk);
		`CHK("quarter phase", qp, qph)
		$display("test reset done");
	endtask
	// Timer source, entry, stack, return, block interrupt line
	task automatic t_timer();
		wr(OFF_CONTROL, 32'h20);
		@(posedge clk);
		tcnt <= 8'hff;
		@(posedge clk);
		tcnt <= 8'h00;
		quiet("blocked");
		rdc("timer flag", OFF_CONTROL, 32'h24);
		wr(OFF_CONTROL, 32'ha4);
		wait_vec();
		`CHK("vector pc", VECTOR_PC, pc_load)
		rdc("global en cleared", OFF_CONTROL, 32'h24);
		`CHK("core pc", VECTOR_PC, pc)
		rdc("status", OFF_IRQ_STS, 32'h1);
		wr(OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq on", 1'h1, irq)
		wr(OFF_IRQ_STS, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq off", 1'h0, irq)
		wr(OFF_CONTROL, 32'h20);
		ret_req <= '1;
		@(posedge clk);
		ret_req <= '0;
		repeat (4) @(posedge clk);
		`CHK("restored pc", START, pc)
		rdc("global en set", OFF_CONTROL, 32'ha0);
		quiet("no repeat");
		wr(OFF_CONTROL, 32'h0);
		$display("test timer done");
	endtask
	// Pin edges in both modes, latency, port change
	task automatic t_edges();
		wr(OFF_OPTION, 32'h40);
		wr(OFF_CONTROL, 32'h90);
		pin <= '1;
		wait_vec();
		`CHK("latency", 1'h1, lat >= 12 && lat <= 17)
		rdc("ext flag", OFF_CONTROL, 32'h12);
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_OPTION, 32'h0);
		pin <= '0;
		repeat (10) @(posedge clk);
		rdc("falling", OFF_CONTROL, 32'h02);
		wr(OFF_CONTROL, 32'h0);
		pin <= '1;
		repeat (10) @(posedge clk);
		rdc("rise ignored", OFF_CONTROL, 32'h0);
		port <= 4'h8;
		repeat (10) @(posedge clk);
		rdc("port flag", OFF_CONTROL, 32'h01);
		wr(OFF_CONTROL, 32'h0);
		$display("test edges done");
	endtask
	// Peripheral flags gated by the group enable
	task automatic t_periph();
		wr(OFF_PEN_A, 32'h08);
		wr(OFF_CONTROL, 32'h80);
		ev_a <= 8'h08;
		ev_b <= 1'h1;
		@(posedge clk);
		ev_a <= '0;
		ev_b <= '0;
		quiet("group off");
		rdc("flags a", OFF_PFLAG_A, 32'h08);
		rdc("flags b", OFF_PFLAG_B, 32'h01);
		wr(OFF_CONTROL, 32'hc0);
		wait_vec();
		wr(OFF_PFLAG_A, 32'h0);
		wr(OFF_PFLAG_B, 32'h0);
		wr(OFF_CONTROL, 32'h0);
		$display("test periph done");
	endtask
	// Wake from power-down with global enable clear, then set
	task automatic t_wake();
		wr(OFF_CONTROL, 32'h10);
		sleep <= '1;
		pin <= '0;
		repeat (10) @(posedge clk);
		`CHK("wake", 1'h1, wake)
		rdc("wake flag", OFF_CONTROL, 32'h12);
		rdc("wake status", OFF_IRQ_STS, 32'h3);
		`CHK("irq level", 1'h1, irq)
		sleep <= '0;
		quiet("no branch");
		sleep <= '1;
		wr(OFF_CONTROL, 32'h92);
		sleep <= '0;
		wait_vec();
		$display("test wake done");
	endtask
	// Counts, verdict, end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= '1;
		t_reset();
		t_timer();
		t_edges();
		t_periph();
		t_wake();
		results();
	end
endmodule
`default_nettype wire

//--- verilog/irq_ctrl_pkg.sv
// Constants for the microcontroller interrupt controller.
// Assumes a single core clock and an AXI4-Lite register master.
`default_nettype none
package irq_ctrl_pkg;
	// Register byte addresses
	localparam logic [7:0] OFF_CONTROL  = 8'h00;
	localparam logic [7:0] OFF_OPTION   = 8'h04;
	localparam logic [7:0] OFF_PFLAG_A  = 8'h08;
	localparam logic [7:0] OFF_PFLAG_B  = 8'h0c;
	localparam logic [7:0] OFF_PEN_A    = 8'h10;
	localparam logic [7:0] OFF_PEN_B    = 8'h14;
	localparam logic [7:0] OFF_IRQ_STS  = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
	// Control register bit positions; EDGE_BIT is option register bit 6
	localparam int GLB_EN_BIT = 7;
	localparam int GRP_EN_BIT = 6;
	localparam int TOIE_BIT = 5;
	localparam int EXIE_BIT = 4;
	localparam int PCIE_BIT = 3;
	localparam int TOIF_BIT = 2;
	localparam int EXIF_BIT = 1;
	localparam int PCIF_BIT = 0;
	localparam int EDGE_BIT = 6;
	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] OPTION_RST  = 8'hff;
	// Widths: 3 core sources + 8 + 1 peripheral = 12 sources
	localparam int PA_W  = 8;
	localparam int PB_W  = 1;
	localparam int PC_W  = 13;
	localparam int SP_W  = 3;
	localparam int STS_W = 2;
	// Core timing and vector
	localparam logic [1:0]      Q_LAST    = 2'h3;
	localparam logic [1:0]      LAT_LAST  = 2'h2;
	localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;
	localparam logic [7:0]      CNT_MAX   = 8'hff;
	localparam logic [7:0]      CNT_ZERO  = 8'h00;
	// Status bits of the sticky block interrupt, then AXI response codes
	localparam int STS_TAKEN = 0;
	localparam int STS_WAKE  = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- verilog/mcu_irq_ctrl.sv
// Interrupt flags, masking, vectoring, return stack and wake gating.
// Assumes pins from outside the clock domain; timer count and peripheral events are on this clock.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Flags set on their event whatever the own, group or global enables hold.
// R2: Global enable (control bit 7) allows unmasked interrupts; cleared blocks all.
// R3: Global enable with any flag and its enable set takes the interrupt.
// R4: Every reset clears the global enable.
// R5: Return from interrupt pops the saved address and sets global enable.
// R6: Acceptance clears global enable, pushes return address, loads pc 0004h.
// R7: Only the return pc is saved; other context is left to software.
// R8: Software clears the serviced flag before re-enabling interrupts.
// R9: Pin and port change events vector after three or four instruction cycles.
// R10: External pin is edge triggered, rising if option bit 6 set, else falling.
// R11: Valid pin edge sets flag bit 1, masked by enable bit 4.
// R12: Enabled pin interrupt wakes power-down; global enable decides vectoring.
// R13: Timer rollover FFh to 00h sets flag bit 2, masked by bit 5.
// R14: Change on upper port pins 7:4 sets flag bit 0, masked by its enable.
// R15: Two peripheral flag and enable registers, gated as a group by one bit.
// R16: Twelve sources, each with own flag and enable.
// R17: Wake-up by interrupt vectors to 0004h if global enable set, else continues.
// R18: A wake-up leaves at least one flag set.
// R19: Pending flags are held while global enable is clear.
module mcu_irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic              ref_clk_in,        // Core clock, 125 MHz
	input  wire logic              arst_n_in,         // Async reset, active low
	input  wire logic [7:0]        s_axi_awaddr_in,   // Write address
	input  wire logic              s_axi_awvalid_in,  // Write address valid
	output logic                   s_axi_awready_out, // Write address ready
	input  wire logic [31:0]       s_axi_wdata_in,    // Write data
	input  wire logic [3:0]        s_axi_wstrb_in,    // Write strobes
	input  wire logic              s_axi_wvalid_in,   // Write data valid
	output logic                   s_axi_wready_out,  // Write data ready
	output logic [1:0]             s_axi_bresp_out,   // Write response
	output logic                   s_axi_bvalid_out,  // Write response valid
	input  wire logic              s_axi_bready_in,   // Write response ready
	input  wire logic [7:0]        s_axi_araddr_in,   // Read address
	input  wire logic              s_axi_arvalid_in,  // Read address valid
	output logic                   s_axi_arready_out, // Read address ready
	output logic [31:0]            s_axi_rdata_out,   // Read data
	output logic [1:0]             s_axi_rresp_out,   // Read response
	output logic                   s_axi_rvalid_out,  // Read data valid
	input  wire logic              s_axi_rready_in,   // Read data ready
	input  wire logic              ext_irq_pin_in,    // External interrupt pin
	input  wire logic [7:4]        upper_port_pins_in,// Upper port pins
	input  wire logic [7:0]        timer_count_in,    // Eight bit timer count
	input  wire logic [PA_W-1:0]   periph_event_a_in, // Peripheral event pulses, group a
	input  wire logic [PB_W-1:0]   periph_event_b_in, // Peripheral event pulses, group b
	input  wire logic              sleep_in,          // Core is in power-down
	input  wire logic              return_from_irq_in,// Return instruction executing
	input  wire logic [PC_W-1:0]   return_pc_in,      // Address to resume at
	output logic                   vector_out,        // Pulse: load pc with vector
	output logic [PC_W-1:0]        pc_load_out,       // Vector or restored address
	output logic                   restore_out,       // Pulse: load pc from stack
	output logic                   wake_out,          // Level: leave power-down
	output logic [1:0]             qphase_out,        // Quarter-cycle phase
	output logic                   irq_out            // Block interrupt, level
);
	import irq_ctrl_pkg::*;

	typedef struct packed {
		logic                       awr;
		logic                       wr;
		logic                       arr;
		logic                       bv;
		logic                       rv;
		logic                       have_aw;
		logic                       have_w;
		logic [7:0]                 awa;
		logic [31:0]                wd;
		logic [3:0]                 ws;
		logic [1:0]                 bresp;
		logic [1:0]                 rresp;
		logic [31:0]                rdata;
		logic [7:0]                 ctl;
		logic [7:0]                 opt;
		logic [PA_W-1:0]            pfa;
		logic [PA_W-1:0]            pea;
		logic [PB_W-1:0]            pfb;
		logic [PB_W-1:0]            peb;
		logic [STS_W-1:0]           sts;
		logic [STS_W-1:0]           msk;
		logic [2:0]                 ex_s;
		logic [2:0][3:0]            pt_s;
		logic                       ex_acc;
		logic [3:0]                 pt_acc;
		logic [7:0]                 tmr_prev;
		logic [1:0]                 q;
		logic [1:0]                 lat;
		logic                       lat_run;
		logic [7:0][PC_W-1:0]       stack;
		logic [SP_W-1:0]            sp;
		logic                       vec;
		logic                       rst_pc;
		logic                       wake;
		logic                       irq;
		logic [PC_W-1:0]            pcl;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic       ex_edge; // Accepted pin edge of the chosen polarity
	logic       pt_chg;  // Accepted change on a port pin
	logic       t_ovf;   // Timer rolled over
	logic       req;     // Some flag with its enables set
	logic       take;    // Interrupt accepted this cycle
	logic       bnd;     // Instruction boundary
	logic       wdo;     // Register write lands this cycle
	logic [7:0] wb;      // Low byte of the write data

	// Next state of every register
	always_comb
	begin
		s_d       = s_q;
		s_d.vec   = 1'b0;
		s_d.rst_pc = 1'b0;
		wb        = s_q.wd[7:0];
		wdo       = 1'b0;
		// Three flop pin synchronisers; a level counts once stages two and three agree
		s_d.ex_s  = {s_q.ex_s[1:0], ext_irq_pin_in};
		s_d.pt_s  = {s_q.pt_s[1:0], upper_port_pins_in};
		ex_edge   = 1'b0;
		if (s_q.ex_s[2] == s_q.ex_s[1] && s_q.ex_s[2] != s_q.ex_acc)
		begin
			s_d.ex_acc = s_q.ex_s[2];
			ex_edge    = (s_q.ex_s[2] == s_q.opt[EDGE_BIT]); // R10
		end
		pt_chg = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (s_q.pt_s[2][i] == s_q.pt_s[1][i] && s_q.pt_s[2][i] != s_q.pt_acc[i])
			begin
				s_d.pt_acc[i] = s_q.pt_s[2][i];
				pt_chg        = 1'b1;
			end
		end
		s_d.tmr_prev = timer_count_in;
		t_ovf        = (s_q.tmr_prev == CNT_MAX) && (timer_count_in == CNT_ZERO); // R13
		// Quarter-cycle phase; an instruction boundary ends phase three
		s_d.q = s_q.q + 2'h1;
		bnd   = (s_q.q == Q_LAST);

		// AXI4-Lite write: address and data taken in either order
		if (s_axi_awvalid_in && s_q.awr)
		begin
			s_d.have_aw = 1'b1;
			s_d.awa     = s_axi_awaddr_in;
			s_d.awr     = 1'b0;
		end
		if (s_axi_wvalid_in && s_q.wr)
		begin
			s_d.have_w = 1'b1;
			s_d.wd     = s_axi_wdata_in;
			s_d.ws     = s_axi_wstrb_in;
			s_d.wr     = 1'b0;
		end
		if (s_q.have_aw && s_q.have_w && !s_q.bv)
		begin
			wdo         = s_q.ws[0];
			s_d.have_aw = 1'b0;
			s_d.have_w  = 1'b0;
			s_d.bv      = 1'b1;
			s_d.bresp   = RESP_OKAY;
			if (s_q.awa > OFF_IRQ_MASK || s_q.awa[1:0] != 2'h0)
			begin
				s_d.bresp = RESP_SLVERR;
				wdo       = 1'b0;
			end
		end
		if (s_q.bv && s_axi_bready_in)
		begin
			s_d.bv  = 1'b0;
			s_d.awr = 1'b1;
			s_d.wr  = 1'b1;
		end
		// Register writes; a hardware set in the same cycle wins
		if (wdo)
		begin
			unique case (s_q.awa)
				OFF_CONTROL:  s_d.ctl = wb;
				OFF_OPTION:   s_d.opt = wb;
				OFF_PFLAG_A:  s_d.pfa = wb[PA_W-1:0];
				OFF_PFLAG_B:  s_d.pfb = wb[PB_W-1:0];
				OFF_PEN_A:    s_d.pea = wb[PA_W-1:0];
				OFF_PEN_B:    s_d.peb = wb[PB_W-1:0];
				OFF_IRQ_STS:  s_d.sts = s_q.sts & ~wb[STS_W-1:0];
				OFF_IRQ_MASK: s_d.msk = wb[STS_W-1:0];
				default:      s_d.ctl = s_q.ctl;
			endcase
		end
		// Event flags set regardless of any enable and held until cleared
		if (ex_edge)
			s_d.ctl[EXIF_BIT] = 1'b1; // R1 R11
		if (t_ovf)
			s_d.ctl[TOIF_BIT] = 1'b1; // R1 R13
		if (pt_chg)
			s_d.ctl[PCIF_BIT] = 1'b1; // R1 R14
		s_d.pfa = s_d.pfa | periph_event_a_in; // R1 R15
		s_d.pfb = s_d.pfb | periph_event_b_in; // R1 R15

		// Any enabled source; group bit gates the peripheral registers
		req = (s_q.ctl[EXIF_BIT] && s_q.ctl[EXIE_BIT])
			|| (s_q.ctl[TOIF_BIT] && s_q.ctl[TOIE_BIT])
			|| (s_q.ctl[PCIF_BIT] && s_q.ctl[PCIE_BIT])
			|| (s_q.ctl[GRP_EN_BIT] && ((|(s_q.pfa & s_q.pea)) || (|(s_q.pfb & s_q.peb)))); // R3 R15 R16
		// Wake from power-down needs only flag and enable
		s_d.wake = sleep_in && req; // R12 R17 R18
		if (sleep_in && req && !s_q.wake)
			s_d.sts[STS_WAKE] = 1'b1;
		// Boundary counter fixes vectoring three or four instruction cycles after an event
		if (!(req && s_q.ctl[GLB_EN_BIT]) || sleep_in) // R19
		begin
			s_d.lat_run = 1'b0;
			s_d.lat     = 2'h0;
		end
		else if (bnd)
		begin
			s_d.lat_run = 1'b1;
			s_d.lat     = s_q.lat + 2'h1; // Boundaries seen; the third one takes
		end
		take = bnd && s_q.lat_run && (s_q.lat == LAT_LAST) && s_q.ctl[GLB_EN_BIT] && req && !sleep_in; // R2 R9

		// Entry: clear global enable, save only the return pc, load vector
		if (take)
		begin
			s_d.ctl[GLB_EN_BIT] = 1'b0; // R6
			s_d.stack[s_q.sp] = return_pc_in; // R6 R7
			s_d.sp            = s_q.sp + 3'h1;
			s_d.vec           = 1'b1;
			s_d.pcl           = VECTOR_PC; // R6 R17
			s_d.lat_run       = 1'b0;
			s_d.lat           = 2'h0;
			s_d.sts[STS_TAKEN] = 1'b1;
		end
		else if (return_from_irq_in)
		begin
			s_d.ctl[GLB_EN_BIT] = 1'b1; // R5
			s_d.sp           = s_q.sp - 3'h1;
			s_d.pcl          = s_q.stack[s_q.sp - 3'h1]; // R5
			s_d.rst_pc       = 1'b1;
		end

		// AXI4-Lite read with registered data
		if (s_axi_arvalid_in && s_q.arr)
		begin
			s_d.arr   = 1'b0;
			s_d.rv    = 1'b1;
			s_d.rresp = RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			unique case (s_axi_araddr_in)
				OFF_CONTROL:  s_d.rdata[7:0] = s_q.ctl;
				OFF_OPTION:   s_d.rdata[7:0] = s_q.opt;
				OFF_PFLAG_A:  s_d.rdata[PA_W-1:0] = s_q.pfa;
				OFF_PFLAG_B:  s_d.rdata[PB_W-1:0] = s_q.pfb;
				OFF_PEN_A:    s_d.rdata[PA_W-1:0] = s_q.pea;
				OFF_PEN_B:    s_d.rdata[PB_W-1:0] = s_q.peb;
				OFF_IRQ_STS:  s_d.rdata[STS_W-1:0] = s_q.sts;
				OFF_IRQ_MASK: s_d.rdata[STS_W-1:0] = s_q.msk;
				default:      s_d.rresp = RESP_SLVERR;
			endcase
		end
		if (s_q.rv && s_axi_rready_in)
		begin
			s_d.rv  = 1'b0;
			s_d.arr = 1'b1;
		end
		// Level interrupt from unmasked sticky status
		s_d.irq = |(s_d.sts & s_d.msk);
	end

	// State register; reset clears the global enable and all else but the option register and the ready flags
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			s_q     <= '0;
			s_q.ctl <= CONTROL_RST; // R4
			s_q.opt <= OPTION_RST;
			s_q.awr <= 1'b1;
			s_q.wr  <= 1'b1;
			s_q.arr <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_awready_out = s_q.awr;
	assign s_axi_wready_out  = s_q.wr;
	assign s_axi_bvalid_out  = s_q.bv;
	assign s_axi_bresp_out   = s_q.bresp;
	assign s_axi_arready_out = s_q.arr;
	assign s_axi_rvalid_out  = s_q.rv;
	assign s_axi_rdata_out   = s_q.rdata;
	assign s_axi_rresp_out   = s_q.rresp;
	assign vector_out        = s_q.vec;
	assign restore_out       = s_q.rst_pc;
	assign pc_load_out       = s_q.pcl;
	assign wake_out          = s_q.wake;
	assign qphase_out        = s_q.q;
	assign irq_out           = s_q.irq;

	// Checks
	vec_clears_en_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R6
		vector_out |-> !s_q.ctl[GLB_EN_BIT] && pc_load_out == VECTOR_PC)
		else $error("vector without global enable clear or wrong address");
	vec_needs_en_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R2
		vector_out |-> $past(s_q.ctl[GLB_EN_BIT]))
		else $error("vector taken with global enable clear");
	ret_sets_en_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R5
		return_from_irq_in && !take |=> s_q.ctl[GLB_EN_BIT] && restore_out)
		else $error("return did not set global enable");
	push_return_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R6
		take |=> s_q.stack[$past(s_q.sp)] == $past(return_pc_in) && s_q.sp == $past(s_q.sp) + 3'h1)
		else $error("return address not pushed on entry");
	wake_pin_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R12
		sleep_in && s_q.ctl[EXIF_BIT] && s_q.ctl[EXIE_BIT] |=> wake_out)
		else $error("enabled pin flag did not wake the core");
	port_flag_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R14
		pt_chg |=> s_q.ctl[PCIF_BIT])
		else $error("port change did not set flag");
	flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R1
		t_ovf |=> s_q.ctl[TOIF_BIT])
		else $error("timer rollover did not set flag");
	pin_edge_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R11
		ex_edge |=> s_q.ctl[EXIF_BIT])
		else $error("pin edge did not set flag");
	edge_sense_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R10
		ex_edge |-> s_q.ex_s[2] == s_q.opt[EDGE_BIT])
		else $error("edge of wrong polarity accepted");
	take_latency_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R9
		$rose(req && s_q.ctl[GLB_EN_BIT]) && !sleep_in && !return_from_irq_in
		##1 (req && s_q.ctl[GLB_EN_BIT] && !sleep_in && !return_from_irq_in)[*8] |-> ##[0:8] vector_out)
		else $error("interrupt not vectored in time");
	wake_flag_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R18
		wake_out |-> $past((|s_q.ctl[TOIF_BIT:PCIF_BIT]) || (|s_q.pfa) || (|s_q.pfb)))
		else $error("wake without a flag set");
	hold_flags_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R19
		s_q.ctl[TOIF_BIT] && !s_q.ctl[GLB_EN_BIT] && !wdo |=> s_q.ctl[TOIF_BIT])
		else $error("pending flag lost while disabled");
endmodule
`default_nettype wire
